//--- bench/adcs_conv_model.sv
/* converter core model: a fresh 12-bit result at each start pulse
   assumes the request struct of the package and a single clock */
`timescale 1ns/100ps
module adcs_conv_model
    import adcs_pkg::*;
(
    // clock and reset
    input  wire logic           mclk,
    input  wire logic           rst,
    // converter link
    input  wire adcs_conv_req_s conv_req,
    output logic      [11:0]    conv_data
);
    ////////////////////////////////////////
    // result counts up from A00, held through the whole window
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            conv_data <= 12'h9FF;
        end else if (conv_req.start && conv_req.power) begin
            conv_data <= conv_data + 12'h001;
        end
    end
endmodule

//--- bench/tb_adcs_sequencer.sv
/* self-checking bench for the sample sequencer
   assumes the converter model and a 10 MHz clock */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_adcs_sequencer
    import adcs_pkg::*;
;
    logic           MCLK = 0, RST = 1, WR = 0, RD = 0;
    logic [31:0]    ADDR = 0, WDATA = 0, RDATA;
    logic           IRQ;
    adcs_conv_req_s CONV_REQ;
    logic [11:0]    CONV_DATA;
    int             failures = 0, checked = 0, seed = 85, gap, n;
    logic [7:0]     mask;
    logic           sp;
    ////////////////////////////////////////
    // clock and instances
    always #50 MCLK = ~MCLK;
    adcs_sequencer dut (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .CONV_REQ(CONV_REQ), .CONV_DATA(CONV_DATA));
    adcs_conv_model conv (.mclk(MCLK), .rst(RST), .conv_req(CONV_REQ), .conv_data(CONV_DATA));
    ////////////////////////////////////////
    // verdict and bus tasks
    task finish_test;
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1;
        @(posedge MCLK);
        WR <= 0;
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] e);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1;
        @(posedge MCLK);
        RD <= 0;
        @(negedge MCLK);
        `CHK(RDATA, e)
    endtask
    // bounded wait for the next start pulse, gap in cycles
    task wait_start(output int g);
        g = 0;
        do begin
            @(negedge MCLK);
            g++;
        end while (CONV_REQ.start !== 1'b1 && g < 400);
        if (g >= 400) begin
            failures++;
            finish_test();
        end
    endtask
    function automatic int rate_cyc(input int r);
        return CLK_HZ / (RATE_80K_SPS << r);
    endfunction
    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge MCLK);
        RST <= 0;
        rdc(ADDR_MODE_CTRL, MODE_RESET);
        rdc(ADDR_FULL_STATUS, 32'h0);
        rdc(32'h4005_0048, 32'h0);
        mask = 8'($random(seed)) | 8'h04;
        wr(ADDR_FULL_MASK, {24'h0, mask});
        wr(ADDR_MODE_CTRL, 32'h14);
        wr(ADDR_MANUAL_CTRL, 32'h48);
        for (int i = 0; i < 64; i++) begin
            wait_start(gap);
            if (i > 1) `CHK(gap, 31)
            `CHK({CONV_REQ.pair, CONV_REQ.se_pos, CONV_REQ.se_neg}, 5'h08)
        end
        repeat (18) @(negedge MCLK);
        rdc(ADDR_FULL_STATUS, 32'h04);
        `CHK(IRQ, 1'b1)
        rdc(32'h4005_0500, 32'h0A01_0A00);
        rdc(32'h4005_057C, 32'h0A3F_0A3E);
        wr(ADDR_MANUAL_CTRL, 32'h40);
        repeat (3) @(negedge MCLK);
        n = 0;
        repeat (200) @(negedge MCLK) n += int'(CONV_REQ.start);
        `CHK(n, 0)
        wr(ADDR_FULL_CLEAR, 32'hFB);
        rdc(ADDR_FULL_STATUS, 32'h04);
        wr(ADDR_FULL_CLEAR, 32'h04);
        rdc(ADDR_FULL_STATUS, 32'h00);
        `CHK(IRQ, 1'b0)
        wr(ADDR_MANUAL_CTRL, 32'h48);
        for (int r = 0; r < 3; r++) begin
            wr(ADDR_MODE_CTRL, 32'h10 | (r << 1));
            repeat (3) wait_start(gap);
            `CHK(gap, rate_cyc(r))
        end
        // every pair code, single-ended sides drawn at random, never both
        for (int p = 0; p < 5; p++) begin
            sp = 1'($random(seed));
            wr(ADDR_MANUAL_CTRL, 32'h08 | (p << 5) | (sp << 8) | ((!sp && p[0]) << 11));
            repeat (2) wait_start(gap);
            `CHK({CONV_REQ.pair, CONV_REQ.se_pos, CONV_REQ.se_neg}, {3'(p), sp, !sp && p[0]})
        end
        wr(ADDR_SWEEP_CFG0, 32'h0000_0010);
        wr(ADDR_MODE_CTRL, 32'h08);
        repeat (3) wait_start(gap);
        `CHK(CONV_REQ.tconv_long, 1'b1)
        `CHK(CONV_REQ.pair, 3'h0)
        // 3T at 256k base is 24 cycles, then the long window, then one deciding cycle
        `CHK(gap, 24 + TCONV_LONG_CYC + 1)
        finish_test();
    end
endmodule

//--- rtl/adcs_pkg.sv
/*
 * Package for the converter sample sequencer: register byte addresses,
 * field positions, reset values, timing counts and the carrier types.
 * Assumes a 10 MHz system clock and a 32-bit plain register port.
 */
package adcs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned RATE_80K_SPS    = 80_000;
    localparam int unsigned RATE_160K_SPS   = 160_000;
    localparam int unsigned RATE_320K_SPS   = 320_000;
    localparam int unsigned BASE_256K_SPS   = 256_000;
    localparam int unsigned BASE_320K_SPS   = 320_000;
    localparam int unsigned TCONV_SHORT_NS  = 1560;
    localparam int unsigned TCONV_LONG_NS   = 2340;
    localparam int unsigned TICK_HZ         = 1_280_000;
    localparam int unsigned TICK_MIN_320    = 2;
    localparam int unsigned TICK_MIN_256    = 3;
    localparam int unsigned TICK_STEP       = 4;
    // periods are longest times: round down
    localparam int unsigned MANUAL_CYC_80K  = CLK_HZ / RATE_80K_SPS;
    localparam int unsigned MANUAL_CYC_160K = CLK_HZ / RATE_160K_SPS;
    localparam int unsigned MANUAL_CYC_320K = CLK_HZ / RATE_320K_SPS;
    localparam int unsigned BASE_CYC_256K   = CLK_HZ / BASE_256K_SPS;
    localparam int unsigned BASE_CYC_320K   = CLK_HZ / BASE_320K_SPS;
    // conversion times are least times: round up
    localparam int unsigned TCONV_SHORT_CYC = (TCONV_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TCONV_LONG_CYC  = (TCONV_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] ADDR_MANUAL_CTRL = 32'h4000_F048;
    localparam logic [31:0] ADDR_SWEEP_CFG0  = 32'h4000_F06C;
    localparam logic [31:0] ADDR_SWEEP_CFG1  = 32'h4000_F070;
    localparam logic [31:0] ADDR_MODE_CTRL   = 32'h4000_F07C;
    localparam logic [31:0] ADDR_FULL_CLEAR  = 32'h4005_0038;
    localparam logic [31:0] ADDR_FULL_STATUS = 32'h4005_003C;
    localparam logic [31:0] ADDR_FULL_MASK   = 32'h4005_0040;
    localparam logic [31:0] ADDR_SEQ_STATE   = 32'h4005_0044;
    localparam logic [31:0] ADDR_MEM_FIRST   = 32'h4005_0400;
    localparam logic [31:0] ADDR_MEM_LAST    = 32'h4005_07FF;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int unsigned MODE_MANUAL_BIT = 4;
    localparam int unsigned MODE_TCONV_BIT  = 3;
    localparam int unsigned MODE_RATE_LSB   = 1;
    localparam int unsigned MODE_BASE_BIT   = 0;
    localparam int unsigned MAN_SE_NEG_BIT  = 11;
    localparam int unsigned MAN_SE_POS_BIT  = 8;
    localparam int unsigned MAN_PAIR_LSB    = 5;
    localparam int unsigned MAN_PWR_BIT     = 3;
    localparam logic [31:0] MODE_RESET      = 32'h0000_0010;
    localparam logic [31:0] MANUAL_RESET    = 32'h0000_0000;
    localparam logic [31:0] SWEEP_RESET     = 32'h0000_0000;
    localparam logic [7:0]  MASK_RESET      = 8'h00;
    localparam logic [2:0]  PAIR_C          = 3'h4;
    localparam logic [5:0]  LAST_SLOT       = 6'h3F;

    ////////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic [8:0] unused;
        logic       one_shot;
        logic       diff;
        logic       enable;
        logic [3:0] sample_time;
    } adcs_chcfg_s;

    typedef struct packed {
        logic       power;
        logic       sample;
        logic       start;
        logic       tconv_long;
        logic [2:0] pair;
        logic       se_pos;
        logic       se_neg;
    } adcs_conv_req_s;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } adcs_state_e;

endpackage

//--- rtl/adcs_sequencer.sv
/*
 * Sample sequencer for a 12-bit successive-approximation converter:
 * manual and sweep modes, per-channel sample memory, full-region flags.
 * Assumes synchronous inputs on MCLK and a converter core whose result
 * is valid on CONV_DATA at the end of the timed conversion window.
 */
// Functional notes
// [RULE1] reset leaves manual single-pair conversion active; code resets to manual mode with the power bit at 0, so nothing converts
// [RULE2] manual rate code picks 80k 160k 320k
// [RULE3] manual pair differential unless single-ended enabled
// [RULE4] full 128-byte region sets channel status bit
// [RULE5] each 12-bit result uses one 2-byte slot
// [RULE6] mode bit 4: 1 manual, 0 sweep, resets 1
// [RULE7] sweep conversion time 1.56us or 2.34us
// [RULE8] sweep rate base 256k or 320k
// [RULE9] single-ended positive/negative enables, never both set
// [RULE10] pair select: gain, temp, A, B, C
// [RULE11] power bit gates all sampling
// [RULE12] fixed ordered per-channel regions in sample memory
// [RULE13] status register, one read-only bit per channel
// [RULE14] writing one to clear bit clears status
// [RULE15] sweep mode samples enabled channels unattended
// [RULE16] sweep channel config: time, enable, diff, one-shot
// [RULE17] sample time counted in 1.28MHz periods
// [RULE18] status sticky until cleared, zero writes ignored
// [RULE19] result right-aligned, upper four bits zero
`timescale 1ns/100ps

module adcs_sequencer
    import adcs_pkg::*;
(
    // clock and reset
    input  wire logic           MCLK,
    input  wire logic           RST,
    // register port
    input  wire logic [31:0]    ADDR,
    input  wire logic [31:0]    WDATA,
    input  wire logic           WR,
    input  wire logic           RD,
    output logic      [31:0]    RDATA,
    // interrupt
    output logic                IRQ,
    // converter core
    output adcs_conv_req_s      CONV_REQ,
    input  wire logic [11:0]    CONV_DATA
);

    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    // channel index of a pair code and polarity
    function automatic logic [2:0] ch_of_pair(logic [2:0] pair, logic neg);
        if (pair < 3'h2) begin
            return pair;
        end
        return {2'(pair - 3'h1), neg};
    endfunction

    // pair code that feeds a channel
    function automatic logic [2:0] pair_of_ch(logic [2:0] ch);
        if (ch < 3'h2) begin
            return ch;
        end
        return 3'({1'b0, ch[2:1]}) + 3'h1;
    endfunction

    // manual conversion period in cycles
    function automatic logic [7:0] manual_period(logic [1:0] code);
        unique case (code)
            2'b00:   return 8'(MANUAL_CYC_80K);
            2'b01:   return 8'(MANUAL_CYC_160K);
            default: return 8'(MANUAL_CYC_320K);
        endcase
    endfunction

    // sweep sample time: 1.28 MHz periods turned into cycles, rounded up
    function automatic logic [9:0] sample_cycles(logic [3:0] code, logic base320);
        int unsigned periods;
        periods = (base320 ? TICK_MIN_320 : TICK_MIN_256) + TICK_STEP * code;
        return 10'((periods * CLK_HZ + TICK_HZ - 1) / TICK_HZ); // see [RULE17]
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers and decode
    logic [31:0]    manual_ctrl;
    logic [31:0]    mode_ctrl;
    logic [31:0]    sweep_cfg0;
    logic [31:0]    sweep_cfg1;
    logic [7:0]     full_status;
    logic [7:0]     full_mask;
    logic [7:0]     set_vec;
    logic [7:0]     clr_vec;
    logic           wr_cfg;
    logic           manual_mode;
    logic           powered;
    logic           base320;
    logic [2:0]     pair_sel;
    logic           se_pos_eff;
    logic           se_neg_eff;
    logic           manual_valid;
    logic [2:0]     manual_ch;

    assign wr_cfg       = WR && (ADDR == ADDR_SWEEP_CFG0 || ADDR == ADDR_SWEEP_CFG1);
    assign manual_mode  = mode_ctrl[MODE_MANUAL_BIT];              // see [RULE6]
    assign powered      = manual_ctrl[MAN_PWR_BIT];                // see [RULE11]
    assign base320      = mode_ctrl[MODE_BASE_BIT];                // see [RULE8]
    assign pair_sel     = manual_ctrl[MAN_PAIR_LSB +: 3];
    // both enables set is illegal; fall back to differential
    assign se_pos_eff   = manual_ctrl[MAN_SE_POS_BIT] && !manual_ctrl[MAN_SE_NEG_BIT]; // see [RULE9]
    assign se_neg_eff   = manual_ctrl[MAN_SE_NEG_BIT] && !manual_ctrl[MAN_SE_POS_BIT]; // see [RULE9]
    assign manual_valid = pair_sel <= PAIR_C;                      // see [RULE10]
    assign manual_ch    = ch_of_pair(pair_sel, se_neg_eff);        // see [RULE10]
    assign clr_vec      = (WR && ADDR == ADDR_FULL_CLEAR) ? WDATA[7:0] : 8'h00;

    // software registers; mode resets to manual
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            manual_ctrl <= MANUAL_RESET;
            mode_ctrl   <= MODE_RESET;                            // see [RULE1]
            sweep_cfg0  <= SWEEP_RESET;
            sweep_cfg1  <= SWEEP_RESET;
            full_mask   <= MASK_RESET;
        end else if (WR) begin
            if (ADDR == ADDR_MANUAL_CTRL) manual_ctrl <= WDATA;
            if (ADDR == ADDR_MODE_CTRL)   mode_ctrl   <= WDATA;
            if (ADDR == ADDR_SWEEP_CFG0)  sweep_cfg0  <= WDATA;
            if (ADDR == ADDR_SWEEP_CFG1)  sweep_cfg1  <= WDATA;
            if (ADDR == ADDR_FULL_MASK)   full_mask   <= WDATA[7:0];
        end
    end

    // full flags: sticky, write-one-to-clear, a new event wins over a clear
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            full_status <= 8'h00;
        end else begin
            full_status <= (full_status & ~clr_vec) | set_vec;    // see [RULE14] [RULE18]
        end
    end

    assign IRQ = |(full_status & full_mask);

    ////////////////////////////////////////////////////////////////////////////
    // sweep channel selection
    adcs_chcfg_s    cfg [0:3];
    logic [3:0]     shot_done;
    logic [3:0]     sweep_ready;
    logic [1:0]     sweep_idx;
    logic [1:0]     next_idx;
    logic           any_ready;

    assign cfg[0] = sweep_cfg0[15:0];
    assign cfg[1] = sweep_cfg0[31:16];
    assign cfg[2] = sweep_cfg1[15:0];
    assign cfg[3] = sweep_cfg1[31:16];

    // enabled channels, less one-shot channels already taken
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sweep_ready[i] = cfg[i].enable && !(cfg[i].one_shot && shot_done[i]); // see [RULE16]
        end
    end

    // next ready channel in order after the last one
    always_comb begin
        next_idx  = sweep_idx;
        any_ready = 1'b0;
        for (int k = 4; k >= 1; k--) begin
            if (sweep_ready[2'(sweep_idx + 2'(k))]) begin
                next_idx  = 2'(sweep_idx + 2'(k));
                any_ready = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    adcs_state_e    state;
    logic [7:0]     period_cnt;
    logic [9:0]     phase_cnt;
    logic           op_manual;
    logic [2:0]     cur_ch;
    logic           conv_start;
    logic           conv_tlong;
    logic [2:0]     conv_pair;
    logic           conv_se_pos;
    logic           conv_se_neg;
    logic           abort;
    logic           store_en;
    logic [9:0]     tconv_sweep;

    assign abort       = !powered || (op_manual != manual_mode);
    assign store_en    = (state == ST_CONVERT) && (phase_cnt == 10'h000) && !abort;
    assign tconv_sweep = mode_ctrl[MODE_TCONV_BIT] ? 10'(TCONV_LONG_CYC - 1)
                                                   : 10'(TCONV_SHORT_CYC - 1); // see [RULE7]

    // state machine: rate slot, sample phase, timed conversion
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state       <= ST_IDLE;
            period_cnt  <= 8'h00;
            phase_cnt   <= 10'h000;
            op_manual   <= 1'b1;
            cur_ch      <= 3'h0;
            sweep_idx   <= 2'h3;
            conv_start  <= 1'b0;
            conv_tlong  <= 1'b0;
            conv_pair   <= 3'h0;
            conv_se_pos <= 1'b0;
            conv_se_neg <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (period_cnt != 8'h00) begin
                period_cnt <= period_cnt - 8'h01;
            end
            if (!powered) begin
                state <= ST_IDLE;                                 // see [RULE11]
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (period_cnt == 8'h00) begin
                            if (manual_mode && manual_valid) begin
                                // manual: one pair at the selected rate
                                period_cnt  <= manual_period(mode_ctrl[MODE_RATE_LSB +: 2]) - 8'h01; // see [RULE2]
                                phase_cnt   <= 10'(TCONV_SHORT_CYC - 1);
                                op_manual   <= 1'b1;
                                cur_ch      <= manual_ch;
                                conv_pair   <= pair_sel;
                                conv_se_pos <= se_pos_eff;        // see [RULE3]
                                conv_se_neg <= se_neg_eff;        // see [RULE3]
                                conv_tlong  <= 1'b0;
                                conv_start  <= 1'b1;
                                state       <= ST_CONVERT;
                            end else if (!manual_mode && any_ready) begin
                                // sweep: next enabled channel, no software help
                                period_cnt  <= (base320 ? 8'(BASE_CYC_320K)
                                                        : 8'(BASE_CYC_256K)) - 8'h01; // see [RULE8]
                                phase_cnt   <= sample_cycles(cfg[next_idx].sample_time,
                                                             base320) - 10'h001; // see [RULE17]
                                op_manual   <= 1'b0;
                                sweep_idx   <= next_idx;          // see [RULE15]
                                cur_ch      <= {1'b0, next_idx};
                                conv_pair   <= pair_of_ch({1'b0, next_idx});
                                conv_se_pos <= !next_idx[0] && next_idx[1]
                                               && !cfg[next_idx].diff; // see [RULE16]
                                conv_se_neg <= next_idx[0] && next_idx[1];
                                conv_tlong  <= mode_ctrl[MODE_TCONV_BIT];
                                state       <= ST_SAMPLE;
                            end
                        end
                    end
                    ST_SAMPLE: begin
                        if (abort) begin
                            state <= ST_IDLE;
                        end else if (phase_cnt == 10'h000) begin
                            phase_cnt  <= tconv_sweep;            // see [RULE7]
                            conv_start <= 1'b1;
                            state      <= ST_CONVERT;
                        end else begin
                            phase_cnt <= phase_cnt - 10'h001;
                        end
                    end
                    ST_CONVERT: begin
                        if (abort || phase_cnt == 10'h000) begin
                            state <= ST_IDLE;
                        end else begin
                            phase_cnt <= phase_cnt - 10'h001;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign CONV_REQ = '{power:      powered,
                        sample:     (state == ST_SAMPLE),
                        start:      conv_start,
                        tconv_long: conv_tlong,
                        pair:       conv_pair,
                        se_pos:     conv_se_pos,
                        se_neg:     conv_se_neg};

    // one-shot bookkeeping: cleared on reconfiguration or manual mode
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            shot_done <= 4'h0;
        end else if (wr_cfg || manual_mode) begin
            shot_done <= 4'h0;
        end else if (store_en && !op_manual) begin
            shot_done[cur_ch[1:0]] <= 1'b1;                       // see [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample memory: 8 regions of 64 half-words
    logic [15:0]    mem [0:511];
    logic [5:0]     wr_ptr [0:7];
    logic [8:0]     rd_idx;
    logic [31:0]    rd_mux;

    assign set_vec = (store_en && wr_ptr[cur_ch] == LAST_SLOT)
                     ? (8'h01 << cur_ch) : 8'h00;                 // see [RULE4]

    // write pointers; a full region wraps and refills
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 8; i++) begin
                wr_ptr[i] <= 6'h00;
            end
        end else if (store_en) begin
            wr_ptr[cur_ch] <= wr_ptr[cur_ch] + 6'h01;             // see [RULE5]
        end
    end

    // result store, right-aligned in its half-word
    always_ff @(posedge MCLK) begin
        if (store_en) begin
            mem[{cur_ch, wr_ptr[cur_ch]}] <= {4'h0, CONV_DATA};   // see [RULE19] [RULE12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path
    assign rd_idx = {ADDR[9:2], 1'b0};

    // read data multiplexer; unmapped reads give zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ADDR >= ADDR_MEM_FIRST && ADDR <= ADDR_MEM_LAST) begin
            rd_mux = {mem[rd_idx + 9'h001], mem[rd_idx]};         // see [RULE12]
        end else begin
            unique case (ADDR)
                ADDR_MANUAL_CTRL: rd_mux = manual_ctrl;
                ADDR_MODE_CTRL:   rd_mux = mode_ctrl;
                ADDR_SWEEP_CFG0:  rd_mux = sweep_cfg0;
                ADDR_SWEEP_CFG1:  rd_mux = sweep_cfg1;
                ADDR_FULL_STATUS: rd_mux = {24'h00_0000, full_status}; // see [RULE13]
                ADDR_FULL_MASK:   rd_mux = {24'h00_0000, full_mask};
                ADDR_SEQ_STATE:   rd_mux = {24'h00_0000, op_manual, cur_ch,
                                            2'h0, state};
                default:          rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // read data stand one cycle after the strobe only
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= RD ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [7:0]     since_start;
    logic           cfg_stable;
    logic           cfg_write;
    logic           cfg_wr_d;

    assign cfg_write = WR && (ADDR == ADDR_MODE_CTRL || ADDR == ADDR_MANUAL_CTRL);

    // cycles since the last start, and whether setup stayed unchanged
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            since_start <= 8'h00;
            cfg_stable  <= 1'b0;
            cfg_wr_d    <= 1'b0;
        end else begin
            since_start <= conv_start ? 8'h01 : since_start + 8'(since_start != 8'hFF);
            cfg_wr_d    <= cfg_write;
            // a write at the deciding edge or the start edge spoils the spacing
            if (conv_start) begin
                cfg_stable <= op_manual && !cfg_write && !cfg_wr_d;
            end else if (cfg_write) begin
                cfg_stable <= 1'b0;
            end
        end
    end

    a_reset_manual: assert property (@(posedge MCLK) disable iff (RST) // see [RULE1] [RULE6]
        $past(RST) |-> manual_mode && op_manual)
        else $error("mode not manual after reset");

    a_manual_rate: assert property (@(posedge MCLK) disable iff (RST) // see [RULE2]
        conv_start && op_manual && cfg_stable && powered
        |-> since_start == manual_period(mode_ctrl[MODE_RATE_LSB +: 2]))
        else $error("manual conversion spacing wrong");

    a_power_gates: assert property (@(posedge MCLK) disable iff (RST) // see [RULE11]
        !powered |=> !CONV_REQ.start && !CONV_REQ.sample)
        else $error("sampling while powered down");

    a_se_exclusive: assert property (@(posedge MCLK) disable iff (RST) // see [RULE9] [RULE3]
        !(CONV_REQ.se_pos && CONV_REQ.se_neg))
        else $error("both single-ended sides driven");

    a_tconv_short: assert property (@(posedge MCLK) disable iff (RST) // see [RULE7]
        conv_start && !op_manual && !conv_tlong
        |-> ##15 (store_en || !powered || manual_mode))
        else $error("sweep conversion time wrong");

    a_full_flag: assert property (@(posedge MCLK) disable iff (RST) // see [RULE4] [RULE5]
        store_en && wr_ptr[cur_ch] == LAST_SLOT |=> full_status[$past(cur_ch)])
        else $error("full region did not flag");

    a_store_data: assert property (@(posedge MCLK) disable iff (RST) // see [RULE19]
        store_en |=> mem[$past({cur_ch, wr_ptr[cur_ch]})] == {4'h0, $past(CONV_DATA)})
        else $error("stored sample wrong");

    a_clear_sticky: assert property (@(posedge MCLK) disable iff (RST) // see [RULE14] [RULE18]
        1'b1 |=> full_status == (($past(full_status) & ~$past(clr_vec)) | $past(set_vec)))
        else $error("status flag update wrong");

    a_sweep_enabled: assert property (@(posedge MCLK) disable iff (RST) // see [RULE15] [RULE16]
        $rose(state == ST_SAMPLE) |-> cfg[sweep_idx].enable && !op_manual)
        else $error("sweep sampled a disabled channel");

endmodule
